// [pkg/knob_pkg.sv]
// Purpose: constants for the quadrature knob speed input block
// Assumes: 125 MHz clock, classic wishbone register access
// Notes: velocities are signed pulses per 10,000 seconds
package knob_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_PRESCALE = 5'h04;
   localparam logic [4:0] ADDR_POSTSCALE = 5'h08;
   localparam logic [4:0] ADDR_TMAX = 5'h0c;
   localparam logic [4:0] ADDR_TMIN = 5'h10;
   localparam logic [4:0] ADDR_RAW = 5'h14;
   localparam logic [4:0] ADDR_SCALED = 5'h18;
   localparam logic [4:0] ADDR_SKIP = 5'h1c;
   localparam logic [5:0] ADDR_IRQ_STAT = 6'h20;
   localparam logic [5:0] ADDR_IRQ_MASK = 6'h24;
   // ----------------------------------------
   // control fields and reset values
   // ----------------------------------------
   localparam int CTRL_MODE_BIT = 0;
   localparam int CTRL_INVERT_BIT = 1;
   localparam int CTRL_POWER_BIT = 2;
   localparam logic [31:0] PRESCALE_RST = 32'h0000_0001;
   localparam logic [31:0] POSTSCALE_RST = 32'h0000_0001;
   localparam logic [31:0] TMAX_RST = 32'h0000_00c8;
   localparam logic [31:0] TMIN_RST = 32'hffff_ff38;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   localparam logic [31:0] ONE32 = 32'h0000_0001;
   // irq bits: 0 = count, 1 = skip, 2 = clamp
   localparam int IRQ_W = 3;
   localparam int IRQ_COUNT_BIT = 0;
   localparam int IRQ_SKIP_BIT = 1;
   localparam int IRQ_CLAMP_BIT = 2;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int MIN_GAP_US = 100;
   localparam int MIN_GAP_CYC = MIN_GAP_US * CLK_MHZ;
endpackage

// [verilog/quadrature_knob_speed_input.sv]
// Purpose: quadrature knob decoder, scaler and bounded target velocity source
// Assumes: pins synchronous to clk_i, wishbone classic slave, one-cycle ack
// Notes: scaled input is the target velocity only while encoder mode is set
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module quadrature_knob_speed_input #(
   parameter int W = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rx_pin_i,
   input wire logic tx_pin_i,
   output logic tx_pin_o,
   output logic tx_pin_oe_o,
   input wire logic serial_tx_i,
   output logic serial_rx_o,
   input wire logic [5:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   output logic [W-1:0] target_velocity_o,
   output logic invert_dir_o,
   output logic irq_o
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [31:0] ctrl;
   logic [W-1:0] prescale;
   logic [W-1:0] postscale;
   logic [W-1:0] tmax;
   logic [W-1:0] tmin;
   logic [W-1:0] raw;
   logic [W-1:0] scaled;
   logic [W-1:0] pre_acc;
   logic [31:0] skip_cnt;
   logic [knob_pkg::IRQ_W-1:0] irq_stat;
   logic [knob_pkg::IRQ_W-1:0] irq_mask;
   logic [1:0] ab_prev;
   logic ack;

   // ----------------------------------------
   // local constants
   // ----------------------------------------
   // the pins idle high through their pull-ups; resetting the history there avoids a false edge
   localparam logic [1:0] AB_IDLE = 2'b11;
   localparam logic [3:0] SEL_ALL = 4'hf;
   localparam logic signed [W-1:0] STEP_ONE = {{(W-1){1'b0}}, 1'b1};

   // ----------------------------------------
   // pin sharing
   // ----------------------------------------
   wire enc_mode = ctrl[knob_pkg::CTRL_MODE_BIT];
   wire power_on = ctrl[knob_pkg::CTRL_POWER_BIT];
   // in encoder mode tx becomes an input so the encoder is never driven against
   assign tx_pin_o = serial_tx_i;
   assign tx_pin_oe_o = !enc_mode;
   assign serial_rx_o = enc_mode ? 1'b1 : rx_pin_i;
   assign invert_dir_o = ctrl[knob_pkg::CTRL_INVERT_BIT];

   // ----------------------------------------
   // quadrature decode
   // ----------------------------------------
   // channel a on rx, b on tx; swapping wires flips sign naturally
   wire [1:0] ab = {rx_pin_i, tx_pin_i};
   wire [1:0] chg = ab ^ ab_prev;
   wire one_edge = enc_mode && (chg == 2'b01 || chg == 2'b10);
   wire both_edge = enc_mode && (chg == 2'b11);
   // forward when new a differs from old b
   wire fwd = ab[1] ^ ab_prev[0];
   wire step_valid = one_edge && power_on;
   wire step_skip = both_edge && power_on;

   // ----------------------------------------
   // scaling and clamp
   // ----------------------------------------
   wire signed [W-1:0] pre_s = prescale;
   wire signed [W-1:0] acc_s = pre_acc;
   wire signed [W-1:0] next_acc = fwd ? acc_s + STEP_ONE : acc_s - STEP_ONE;
   // compare by magnitude so a prescaler lowered mid-count still fires
   wire pre_hit = (next_acc >= pre_s) || (next_acc <= -pre_s);
   wire signed [W+1:0] sum_w = fwd ? $signed({{2{scaled[W-1]}}, scaled}) + $signed({2'b00, postscale})
                                   : $signed({{2{scaled[W-1]}}, scaled}) - $signed({2'b00, postscale});
   wire signed [W+1:0] max_w = $signed({{2{tmax[W-1]}}, tmax});
   wire signed [W+1:0] min_w = $signed({{2{tmin[W-1]}}, tmin});
   wire over = sum_w > max_w;
   wire under = sum_w < min_w;
   wire [W-1:0] next_scaled = over ? tmax : under ? tmin : sum_w[W-1:0];
   wire do_scale = step_valid && pre_hit;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire req = cyc_i && stb_i && !ack;
   // writes land on the edge at which the master sees ack, its request still held
   wire take = cyc_i && stb_i && ack;
   wire wr = take && we_i && (sel_i == SEL_ALL);
   wire wr_ctrl = wr && adr_i[4:0] == knob_pkg::ADDR_CTRL && !adr_i[5];
   wire wr_pre = wr && adr_i[4:0] == knob_pkg::ADDR_PRESCALE && !adr_i[5];
   wire wr_post = wr && adr_i[4:0] == knob_pkg::ADDR_POSTSCALE && !adr_i[5];
   wire wr_tmax = wr && adr_i[4:0] == knob_pkg::ADDR_TMAX && !adr_i[5];
   wire wr_tmin = wr && adr_i[4:0] == knob_pkg::ADDR_TMIN && !adr_i[5];
   wire wr_stat = wr && adr_i == knob_pkg::ADDR_IRQ_STAT;
   wire wr_mask = wr && adr_i == knob_pkg::ADDR_IRQ_MASK;
   wire [knob_pkg::IRQ_W-1:0] irq_ev = {do_scale && (over || under), step_skip, step_valid};
   wire [knob_pkg::IRQ_W-1:0] irq_clr = wr_stat ? dat_i[knob_pkg::IRQ_W-1:0] : '0;
   wire [31:0] rd_mux =
      adr_i == {1'b0, knob_pkg::ADDR_CTRL} ? ctrl :
      adr_i == {1'b0, knob_pkg::ADDR_PRESCALE} ? prescale :
      adr_i == {1'b0, knob_pkg::ADDR_POSTSCALE} ? postscale :
      adr_i == {1'b0, knob_pkg::ADDR_TMAX} ? tmax :
      adr_i == {1'b0, knob_pkg::ADDR_TMIN} ? tmin :
      adr_i == {1'b0, knob_pkg::ADDR_RAW} ? raw :
      adr_i == {1'b0, knob_pkg::ADDR_SCALED} ? scaled :
      adr_i == {1'b0, knob_pkg::ADDR_SKIP} ? skip_cnt :
      adr_i == knob_pkg::ADDR_IRQ_STAT ? 32'(irq_stat) :
      adr_i == knob_pkg::ADDR_IRQ_MASK ? 32'(irq_mask) : knob_pkg::ZERO32;

   assign ack_o = ack;
   assign irq_o = |(irq_stat & irq_mask);
   // velocity only leaves the block in encoder speed mode
   assign target_velocity_o = enc_mode ? scaled : '0;

   // ----------------------------------------
   // bus slave and settings
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
         dat_o <= knob_pkg::ZERO32;
         ctrl <= knob_pkg::ZERO32;
         prescale <= knob_pkg::PRESCALE_RST;
         postscale <= knob_pkg::POSTSCALE_RST;
         tmax <= knob_pkg::TMAX_RST;
         tmin <= knob_pkg::TMIN_RST;
         irq_mask <= '0;
      end else begin
         ack <= req;
         dat_o <= req ? rd_mux : dat_o;
         if (wr_ctrl) ctrl <= dat_i;
         // a zero prescaler would fire on every step, the same as one; hold it at one instead
         if (wr_pre) prescale <= (dat_i == knob_pkg::ZERO32) ? knob_pkg::ONE32 : dat_i;
         if (wr_post) postscale <= dat_i;
         if (wr_tmax) tmax <= dat_i;
         if (wr_tmin) tmin <= dat_i;
         if (wr_mask) irq_mask <= dat_i[knob_pkg::IRQ_W-1:0];
      end
   end

   // ----------------------------------------
   // counting datapath
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ab_prev <= AB_IDLE;
         raw <= '0;
         pre_acc <= '0;
         scaled <= '0;
         skip_cnt <= knob_pkg::ZERO32;
      end else begin
         ab_prev <= ab;
         if (!power_on) begin
            raw <= '0;
            pre_acc <= '0;
         end else if (step_valid) begin
            raw <= fwd ? raw + STEP_ONE : raw - STEP_ONE;
            pre_acc <= pre_hit ? '0 : next_acc;
         end
         if (do_scale) scaled <= next_scaled;
         if (step_skip) skip_cnt <= skip_cnt + knob_pkg::ONE32;
      end
   end

   // ----------------------------------------
   // event flags
   // ----------------------------------------
   // one sticky bit per event; a set in the cycle of its clear wins so no event is lost
   for (genvar i = 0; i < knob_pkg::IRQ_W; i++) begin : g_irq
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            irq_stat[i] <= 1'b0;
         end else if (irq_ev[i]) begin
            irq_stat[i] <= 1'b1;
         end else if (irq_clr[i]) begin
            irq_stat[i] <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_power_zero;
      @(posedge clk_i) disable iff (rst_i) !power_on |=> raw == '0;
   endproperty
   a_power_zero: assert property (p_power_zero) else $error("raw count not held at zero");

   property p_skip_inc;
      @(posedge clk_i) disable iff (rst_i) step_skip |=> skip_cnt == $past(skip_cnt) + 1;
   endproperty
   a_skip_inc: assert property (p_skip_inc) else $error("skip counter did not advance");

   property p_bounds;
      @(posedge clk_i) disable iff (rst_i)
         do_scale |=> ($signed(scaled) <= $signed(tmax)) && ($signed(scaled) >= $signed(tmin));
   endproperty
   a_bounds: assert property (p_bounds) else $error("scaled value out of bounds");

   property p_count_dir;
      @(posedge clk_i) disable iff (rst_i) step_valid && fwd |=> raw == $past(raw) + 1;
   endproperty
   a_count_dir: assert property (p_count_dir) else $error("forward edge did not count up");

   property p_tx_release;
      @(posedge clk_i) disable iff (rst_i) enc_mode |-> !tx_pin_oe_o;
   endproperty
   a_tx_release: assert property (p_tx_release) else $error("tx driven in encoder mode");

   property p_mode_vel;
      @(posedge clk_i) disable iff (rst_i) enc_mode |-> target_velocity_o == scaled;
   endproperty
   a_mode_vel: assert property (p_mode_vel) else $error("velocity not from scaled input");

   property p_double_no_count;
      @(posedge clk_i) disable iff (rst_i) both_edge && power_on |=> raw == $past(raw);
   endproperty
   a_double_no_count: assert property (p_double_no_count) else $error("double change counted");

   property p_scale_only_on_hit;
      @(posedge clk_i) disable iff (rst_i) !do_scale |=> scaled == $past(scaled);
   endproperty
   a_scale_only_on_hit: assert property (p_scale_only_on_hit) else $error("scaled moved without step");

   property p_reset_scale;
      @(posedge clk_i) $fell(rst_i) |-> prescale == 1 && postscale == 1;
   endproperty
   a_reset_scale: assert property (p_reset_scale) else $error("scale defaults wrong");

   property p_count_down;
      @(posedge clk_i) disable iff (rst_i) step_valid && !fwd |=> raw == $past(raw) - STEP_ONE;
   endproperty
   a_count_down: assert property (p_count_down) else $error("backward edge did not count down");

   property p_count_flag;
      @(posedge clk_i) disable iff (rst_i) step_valid |=> irq_stat[knob_pkg::IRQ_COUNT_BIT];
   endproperty
   a_count_flag: assert property (p_count_flag) else $error("count event not flagged");

   property p_serial_no_count;
      @(posedge clk_i) disable iff (rst_i) !enc_mode && power_on |=> raw == $past(raw);
   endproperty
   a_serial_no_count: assert property (p_serial_no_count) else $error("counted in serial mode");

   property p_rx_quiet;
      @(posedge clk_i) disable iff (rst_i) enc_mode |-> serial_rx_o;
   endproperty
   a_rx_quiet: assert property (p_rx_quiet) else $error("serial receive not idle in encoder mode");

   property p_tx_serial;
      @(posedge clk_i) disable iff (rst_i) !enc_mode |-> tx_pin_oe_o && (tx_pin_o == serial_tx_i);
   endproperty
   a_tx_serial: assert property (p_tx_serial) else $error("tx not driven in serial mode");

   property p_pre_zero;
      @(posedge clk_i) disable iff (rst_i) !power_on |=> pre_acc == '0;
   endproperty
   a_pre_zero: assert property (p_pre_zero) else $error("prescale count kept without power");

   property p_skip_needs_power;
      @(posedge clk_i) disable iff (rst_i) !power_on |=> skip_cnt == $past(skip_cnt);
   endproperty
   a_skip_needs_power: assert property (p_skip_needs_power) else $error("skip counted without power");

   property p_skip_hold;
      @(posedge clk_i) disable iff (rst_i) !step_skip |=> skip_cnt == $past(skip_cnt);
   endproperty
   a_skip_hold: assert property (p_skip_hold) else $error("skip counter moved without skip");

   property p_skip_flag;
      @(posedge clk_i) disable iff (rst_i) step_skip |=> irq_stat[knob_pkg::IRQ_SKIP_BIT];
   endproperty
   a_skip_flag: assert property (p_skip_flag) else $error("skip event not flagged");

   property p_scale_up;
      @(posedge clk_i) disable iff (rst_i)
         do_scale && fwd && !over && !under |=> scaled == $past(scaled) + $past(postscale);
   endproperty
   a_scale_up: assert property (p_scale_up) else $error("scaled input did not rise by postscale");

   property p_scale_down;
      @(posedge clk_i) disable iff (rst_i)
         do_scale && !fwd && !over && !under |=> scaled == $past(scaled) - $past(postscale);
   endproperty
   a_scale_down: assert property (p_scale_down) else $error("scaled input did not fall by postscale");

   property p_pre_wrap;
      @(posedge clk_i) disable iff (rst_i) step_valid && pre_hit |=> pre_acc == '0;
   endproperty
   a_pre_wrap: assert property (p_pre_wrap) else $error("prescale count not restarted");

   property p_pre_count;
      @(posedge clk_i) disable iff (rst_i) step_valid && !pre_hit |=> pre_acc != $past(pre_acc);
   endproperty
   a_pre_count: assert property (p_pre_count) else $error("prescale count did not move");

   property p_reset_bounds;
      @(posedge clk_i) $fell(rst_i) |-> tmax == knob_pkg::TMAX_RST && tmin == knob_pkg::TMIN_RST;
   endproperty
   a_reset_bounds: assert property (p_reset_bounds) else $error("target limits not at defaults");

   property p_vel_off;
      @(posedge clk_i) disable iff (rst_i) !enc_mode |-> target_velocity_o == '0;
   endproperty
   a_vel_off: assert property (p_vel_off) else $error("velocity driven outside encoder mode");

   property p_vel_reset;
      @(posedge clk_i) $fell(rst_i) |-> target_velocity_o == '0;
   endproperty
   a_vel_reset: assert property (p_vel_reset) else $error("velocity not zero after reset");

   property p_sat_max;
      @(posedge clk_i) disable iff (rst_i) do_scale && over |=> scaled == $past(tmax);
   endproperty
   a_sat_max: assert property (p_sat_max) else $error("scaled input not held at maximum");

   property p_sat_min;
      @(posedge clk_i) disable iff (rst_i) do_scale && under && !over |=> scaled == $past(tmin);
   endproperty
   a_sat_min: assert property (p_sat_min) else $error("scaled input not held at minimum");

   property p_clamp_flag;
      @(posedge clk_i) disable iff (rst_i) do_scale && (over || under) |=> irq_stat[knob_pkg::IRQ_CLAMP_BIT];
   endproperty
   a_clamp_flag: assert property (p_clamp_flag) else $error("clamp event not flagged");

   property p_one_edge_counts;
      @(posedge clk_i) disable iff (rst_i) step_valid |=> raw != $past(raw);
   endproperty
   a_one_edge_counts: assert property (p_one_edge_counts) else $error("single edge not counted");

   property p_double_no_scale;
      @(posedge clk_i) disable iff (rst_i) both_edge && power_on |=> pre_acc == $past(pre_acc);
   endproperty
   a_double_no_scale: assert property (p_double_no_scale) else $error("double change moved prescale");

   property p_reset_stat;
      @(posedge clk_i) $fell(rst_i) |-> skip_cnt == '0 && !irq_o;
   endproperty
   a_reset_stat: assert property (p_reset_stat) else $error("skip status not clear after reset");
endmodule
`default_nettype wire

// [tb/knob_encoder.sv]
// Purpose: hand-turned quadrature knob with open-drain contacts
// Assumes: pull-ups on both lines, so a released contact reads high
// Notes: the gap is shortened to keep the run short; the block has no filter
`timescale 1ns/1ns
`default_nettype none
module knob_encoder #(
   parameter int GAP_CYC = 200
) (
   input wire logic clk_i,
   output logic a_low_o,
   output logic b_low_o
);
   // ----------------------------------------
   // phase walk, upward order 00 10 11 01
   // ----------------------------------------
   logic [1:0] seq [4] = '{2'b00, 2'b10, 2'b11, 2'b01};
   int idx = 2;
   initial begin
      a_low_o = 1'b0;
      b_low_o = 1'b0;
   end
   // d = 1 up, 3 down, 2 moves both lines at once
   task automatic turn(input int d);
      idx = (idx + d) % 4;
      @(posedge clk_i);
      a_low_o <= ~seq[idx][1];
      b_low_o <= ~seq[idx][0];
      repeat (GAP_CYC) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Purpose: self-checking bench for the quadrature knob speed input
// Assumes: one-cycle wishbone ack, every line released reads high
// Notes: expected counts follow the knob phase walk of each scenario
`timescale 1ns/1ns
`default_nettype none
module tb;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   logic clk_i = 1'b0, rst_i = 1'b1, serial_tx = 1'b1;
   logic we = 1'b0, cyc = 1'b0, stb = 1'b0, swap = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [31:0] dat = 32'h0, q;
   wire logic [31:0] dat_o, vel;
   wire logic ack, tx_o, tx_oe, srx, inv, irq, a_low, b_low;
   wire logic rx_pin = ~(swap ? b_low : a_low);
   wire logic tx_pin = ~(swap ? a_low : b_low) & (tx_oe ? tx_o : 1'b1);
   int errors = 0;
   int n_compared = 0;
   quadrature_knob_speed_input u_quadrature_knob_speed_input (.clk_i(clk_i), .rst_i(rst_i),
      .rx_pin_i(rx_pin), .tx_pin_i(tx_pin), .tx_pin_o(tx_o), .tx_pin_oe_o(tx_oe), .serial_tx_i(serial_tx),
      .serial_rx_o(srx), .adr_i(adr), .dat_i(dat), .dat_o(dat_o), .we_i(we), .sel_i(4'hf), .cyc_i(cyc),
      .stb_i(stb), .ack_o(ack), .target_velocity_o(vel), .invert_dir_o(inv), .irq_o(irq));
   knob_encoder #(.GAP_CYC(200)) u_knob_encoder (.clk_i(clk_i), .a_low_o(a_low), .b_low_o(b_low));
   initial forever #4 clk_i = ~clk_i;
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // request held until ack is sampled high at a rising edge
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      // no local limit: a slave that never answers is caught by the watchdog
      do @(posedge clk_i); while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic turns(input int d, input int n);
      repeat (n) u_knob_encoder.turn(d);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_serial();
      serial_tx <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(32'({tx_oe, tx_o, srx}), 32'h5);
      chk(vel, knob_pkg::ZERO32);
      rd(6'(knob_pkg::ADDR_PRESCALE), knob_pkg::ONE32);
      rd(6'(knob_pkg::ADDR_POSTSCALE), knob_pkg::ONE32);
      rd(6'h3c, knob_pkg::ZERO32);
      $display("serial mode done");
   endtask
   task automatic t_power();
      wr(6'(knob_pkg::ADDR_CTRL), 32'h1);
      turns(1, 2);
      rd(6'(knob_pkg::ADDR_RAW), knob_pkg::ZERO32);
      chk(32'({tx_oe, srx}), 32'h1);
      $display("power off done");
   endtask
   task automatic t_count();
      wr(6'(knob_pkg::ADDR_POSTSCALE), 32'h0000_000a);
      wr(6'(knob_pkg::ADDR_CTRL), 32'h5);
      turns(1, 3);
      turns(3, 1);
      rd(6'(knob_pkg::ADDR_RAW), 32'h2);
      rd(6'(knob_pkg::ADDR_SCALED), 32'h14);
      chk(vel, 32'h14);
      $display("counting done");
   endtask
   task automatic t_prescale();
      wr(6'(knob_pkg::ADDR_PRESCALE), 32'h4);
      turns(1, 3);
      chk(vel, 32'h14);
      turns(1, 1);
      chk(vel, 32'h1e);
      $display("prescale done");
   endtask
   task automatic t_clamp();
      wr(6'(knob_pkg::ADDR_PRESCALE), 32'h1);
      wr(6'(knob_pkg::ADDR_TMAX), 32'h23);
      wr(6'(knob_pkg::ADDR_TMIN), 32'hffff_fffb);
      turns(1, 2);
      chk(vel, 32'h23);
      turns(3, 5);
      chk(vel, 32'hffff_fffb);
      rd(6'(knob_pkg::ADDR_RAW), 32'h3);
      $display("clamp done");
   endtask
   task automatic t_skip();
      wr(knob_pkg::ADDR_IRQ_MASK, 32'h2);
      turns(2, 1);
      rd(6'(knob_pkg::ADDR_SKIP), 32'h1);
      rd(6'(knob_pkg::ADDR_RAW), 32'h3);
      chk(32'(irq), 32'h1);
      rd(knob_pkg::ADDR_IRQ_STAT, 32'h7);
      wr(knob_pkg::ADDR_IRQ_STAT, 32'h7);
      @(posedge clk_i);
      chk(32'(irq), 32'h0);
      $display("skip done");
   endtask
   // one step first, so the lines sit at 11 and swapping moves neither
   task automatic t_swap();
      turns(1, 1);
      swap <= 1'b1;
      turns(1, 1);
      rd(6'(knob_pkg::ADDR_RAW), 32'h3);
      chk(vel, 32'hffff_fffb);
      wr(6'(knob_pkg::ADDR_CTRL), 32'h7);
      @(posedge clk_i);
      chk(32'(inv), 32'h1);
      $display("swap and invert done");
   endtask
   // ----------------------------------------
   // sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_serial();
      t_power();
      t_count();
      t_prescale();
      t_clamp();
      t_skip();
      t_swap();
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      $display("Error %0t: watchdog", $time);
      give_verdict();
   end
endmodule
`default_nettype wire
